// *** shared/gapped_tx_pkg.sv ***
// Constants, register map and carriers for the gapped DS3 transmit input block
// Assumes a 100 MHz system clock and one AXI4-Lite register port
package gapped_tx_pkg;

  // ============================================================
  // Sizes
  localparam int NUM_CH  = 12;
  localparam int ADDR_W  = 12;
  localparam int CNT_W   = 8;
  localparam int DEPTH_W = 3;
  localparam int NCO_W   = 16;
  localparam int PRBS_W  = 15;

  // ============================================================
  // Register map: printed offset is an index, byte address is four times it
  localparam logic [3:0] CTRL_IDX_LOW = 4'h6;
  localparam logic [3:0] STAT_IDX_LOW = 4'hE;
  localparam logic [3:0] CH_PAGE [NUM_CH] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                              4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] CTRL_RW_MASK = 8'h3F;
  localparam int SINGLE_RAIL_BIT  = 0;
  localparam int RATE_SONET_BIT   = 1;
  localparam int RATE_E3_BIT      = 2;
  localparam int LOCAL_LOOP_BIT   = 3;
  localparam int REMOTE_LOOP_BIT  = 4;
  localparam int TEST_PATTERN_BIT = 5;
  localparam int STAT_CNT_LSB     = 0;
  localparam int STAT_FILL_LSB    = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ============================================================
  // Line rates and pacing
  localparam longint SYS_CLK_HZ  = 100_000_000;
  localparam longint DS3_RATE_HZ = 44_736_000;
  localparam longint E3_RATE_HZ  = 34_368_000;
  localparam longint STS1_RATE_HZ = 51_840_000;
  localparam logic [NCO_W-1:0] NCO_INC_DS3 = NCO_W'((DS3_RATE_HZ << NCO_W) / SYS_CLK_HZ);
  localparam logic [NCO_W-1:0] NCO_INC_E3 = NCO_W'((E3_RATE_HZ << NCO_W) / SYS_CLK_HZ);
  localparam logic [NCO_W-1:0] NCO_INC_STS1 = NCO_W'((STS1_RATE_HZ << NCO_W) / SYS_CLK_HZ);
  localparam logic [NCO_W-1:0] NCO_TRIM = 16'h0400;
  localparam logic [CNT_W-1:0] FILL_HIGH = 8'h06;
  localparam logic [CNT_W-1:0] FILL_LOW  = 8'h02;
  localparam logic [PRBS_W-1:0] PRBS_SEED = 15'h7FFF;

  // ============================================================
  // Carriers
  typedef struct packed {
    logic [1:0] unused;
    logic       testPatternEn;
    logic       remoteLoopbackEn;
    logic       localLoopbackEn;
    logic       rateE3Select;
    logic       rateSonetVsT3Select;
    logic       singleRailSelect;
  } chanCtrl_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axiReq_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axiRsp_t;

  typedef enum logic [1:0] {SlotZero, SlotOne, SlotViol} slot_t;

  function automatic logic [CNT_W-1:0] grayToBin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// *** hw/gapped_bit_capture.sv ***
// Link-side capture of one channel: latches bits on the gapped clock
// Assumes the reader uses the gray write count only after two-flop sync
module gapped_bit_capture
  import gapped_tx_pkg::*;
(
  input  wire logic               clkLink,
  input  wire logic               rst,
  input  wire logic               dataIn,
  input  wire logic [DEPTH_W-1:0] rdAddr,
  output logic                    rdBit,
  output logic [CNT_W-1:0]        wrGray_q
);

  logic [CNT_W-1:0]  wrBin_q;
  logic [CNT_W-1:0]  wrBin_d;
  logic [(1<<DEPTH_W)-1:0] store_q;

  assign wrBin_d = wrBin_q + 8'h01;
  assign rdBit   = store_q[rdAddr];

  // ============================================================
  // Capture, count only on gapped edges
  always_ff @(posedge clkLink or posedge rst) begin
    if (rst) begin
      wrBin_q  <= '0;
      wrGray_q <= '0;
      store_q  <= '0;
    end else begin
      store_q[wrBin_q[DEPTH_W-1:0]] <= dataIn;
      wrBin_q  <= wrBin_d;
      wrGray_q <= wrBin_d ^ (wrBin_d >> 1);
    end
  end

endmodule // gapped_bit_capture

// *** hw/line_pulse_encoder.sv ***
// Bipolar line encoder with three-zero substitution for one channel
// Assumes one bit strobe per line bit period from the pacing logic
module line_pulse_encoder
  import gapped_tx_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic bitStb,
  input  wire logic bitIn,
  input  wire logic singleRail,
  output logic      linePos_q,
  output logic      lineNeg_q,
  output logic      lineClk_q
);

  slot_t s0_q, s1_q, s2_q;
  logic  lastPos_q;
  logic  oddPulses_q;
  logic  runOfThree;
  logic  isPulse;
  logic  pulsePos;

  assign runOfThree = !bitIn && s0_q == SlotZero && s1_q == SlotZero;
  assign isPulse    = s2_q != SlotZero;
  assign pulsePos   = (s2_q == SlotViol) ? lastPos_q : !lastPos_q;

  // ============================================================
  // Substitution pipeline
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s0_q        <= SlotZero;
      s1_q        <= SlotZero;
      s2_q        <= SlotZero;
      oddPulses_q <= 1'b0;
    end else if (bitStb) begin
      if (runOfThree) begin
        s2_q        <= oddPulses_q ? SlotZero : SlotOne;
        s1_q        <= SlotZero;
        s0_q        <= SlotViol;
        oddPulses_q <= 1'b0;
      end else begin
        s2_q        <= s1_q;
        s1_q        <= s0_q;
        s0_q        <= bitIn ? SlotOne : SlotZero;
        oddPulses_q <= oddPulses_q ^ bitIn;
      end
    end
  end

  // ============================================================
  // Line drive
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      linePos_q <= 1'b0;
      lineNeg_q <= 1'b0;
      lineClk_q <= 1'b0;
      lastPos_q <= 1'b0;
    end else if (bitStb) begin
      lineClk_q <= !lineClk_q;
      if (!singleRail) begin
        linePos_q <= bitIn;
        lineNeg_q <= 1'b0;
      end else begin
        linePos_q <= isPulse && pulsePos;
        lineNeg_q <= isPulse && !pulsePos;
        if (isPulse) begin
          lastPos_q <= pulsePos;
        end
      end
    end
  end

endmodule // line_pulse_encoder

// *** hw/gapped_ds3_tx_input.sv ***
// Twelve-channel gapped DS3 transmit input with control registers
// Assumes AXI4-Lite masters and gapped clocks that may stop at any time
//
// Operation
// - Each gapped clock edge latches the data pin as one payload bit.
// - Captured bits pass through the smoothing elastic store before the line.
// - Smoothed bits become bipolar line pulses when control bit 0 is set, else plain bits on linePos.
// - Rate is DS3 when the E3 and SONET rate bits are both clear.
// - Control bit 0 set selects single-rail transmit data.
// - Twelve control registers sit at index m6, m in 0-5 and 8-D.
// - Bits 7:6 read zero; 5 pattern, 4 remote, 3 local loop; reset 0.
//
// Register access over AXI4-Lite was left to the implementer.
module gapped_ds3_tx_input
  import gapped_tx_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  gapped_tx_pkg::axiReq_t     axiReq,
  output gapped_tx_pkg::axiRsp_t     axiRsp,
  input  wire logic [NUM_CH-1:0]     tx_gapped_clock_in,
  input  wire logic [NUM_CH-1:0]     tx_pos_data_in,
  input  wire logic [NUM_CH-1:0]     rxLoopBit,
  input  wire logic [NUM_CH-1:0]     rxLoopValid,
  output logic      [NUM_CH-1:0]     linePos,
  output logic      [NUM_CH-1:0]     lineNeg,
  output logic      [NUM_CH-1:0]     lineBitClk,
  output logic      [NUM_CH-1:0]     localLoopData
);

  // ============================================================
  // Bus slave state
  logic              awHeld_q, awHeld_d;
  logic              wHeld_q, wHeld_d;
  logic              awReady_q, wReady_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0]       wData_q;
  logic [3:0]        wStrb_q;
  logic              bValid_q, bValid_d;
  logic [1:0]        bResp_q;
  logic              arReady_q;
  logic              rValid_q, rValid_d;
  logic [31:0]       rData_q;
  logic [1:0]        rResp_q;

  logic              awTake;
  logic              wTake;
  logic              arTake;
  logic              doWrite;
  logic [NUM_CH-1:0] wrCtrlHit;
  logic [NUM_CH-1:0] rdCtrlHit;
  logic [NUM_CH-1:0] rdStatHit;
  logic              wrAnyHit;
  logic              rdAnyHit;
  logic [31:0]       rdMux;

  chanCtrl_t         ctrl_q [NUM_CH];
  logic [CNT_W-1:0]  wrCount [NUM_CH];
  logic [CNT_W-1:0]  fill [NUM_CH];

  assign awTake  = axiReq.awvalid && awReady_q;
  assign wTake   = axiReq.wvalid && wReady_q;
  assign arTake  = axiReq.arvalid && arReady_q;
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;

  assign awHeld_d = (awHeld_q || awTake) && !doWrite;
  assign wHeld_d  = (wHeld_q || wTake) && !doWrite;
  assign bValid_d = doWrite || (bValid_q && !axiReq.bready);
  assign rValid_d = arTake || (rValid_q && !axiReq.rready);

  assign wrAnyHit = |wrCtrlHit;
  assign rdAnyHit = |rdCtrlHit || |rdStatHit;

  // ============================================================
  // Address decode
  for (genvar c = 0; c < NUM_CH; c++) begin : gDecode
    assign wrCtrlHit[c] = awAddr_q[ADDR_W-1:2] == {2'b00, CH_PAGE[c], CTRL_IDX_LOW};
    assign rdCtrlHit[c] = axiReq.araddr[ADDR_W-1:2] == {2'b00, CH_PAGE[c], CTRL_IDX_LOW};
    assign rdStatHit[c] = axiReq.araddr[ADDR_W-1:2] == {2'b00, CH_PAGE[c], STAT_IDX_LOW};
  end

  always_comb begin
    rdMux = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (rdCtrlHit[c]) begin
        rdMux = {24'h000000, ctrl_q[c] & CTRL_RW_MASK};
      end
      if (rdStatHit[c]) begin
        rdMux = 32'(wrCount[c]) << STAT_CNT_LSB | 32'(fill[c]) << STAT_FILL_LSB;
      end
    end
  end

  // ============================================================
  // Write channel
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awReady_q <= 1'b0;
      wReady_q  <= 1'b0;
      awAddr_q  <= '0;
      wData_q   <= '0;
      wStrb_q   <= '0;
      bValid_q  <= 1'b0;
      bResp_q   <= RESP_OKAY;
    end else begin
      awHeld_q  <= awHeld_d;
      wHeld_q   <= wHeld_d;
      awReady_q <= !awHeld_d && !bValid_d;
      wReady_q  <= !wHeld_d && !bValid_d;
      bValid_q  <= bValid_d;
      if (awTake) begin
        awAddr_q <= axiReq.awaddr;
      end
      if (wTake) begin
        wData_q <= axiReq.wdata;
        wStrb_q <= axiReq.wstrb;
      end
      if (doWrite) begin
        bResp_q <= wrAnyHit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ============================================================
  // Read channel
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      arReady_q <= 1'b0;
      rValid_q  <= 1'b0;
      rData_q   <= '0;
      rResp_q   <= RESP_OKAY;
    end else begin
      arReady_q <= !rValid_d;
      rValid_q  <= rValid_d;
      if (arTake) begin
        rData_q <= rdMux;
        rResp_q <= rdAnyHit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign axiRsp.awready = awReady_q;
  assign axiRsp.wready  = wReady_q;
  assign axiRsp.bvalid  = bValid_q;
  assign axiRsp.bresp   = bResp_q;
  assign axiRsp.arready = arReady_q;
  assign axiRsp.rvalid  = rValid_q;
  assign axiRsp.rdata   = rData_q;
  assign axiRsp.rresp   = rResp_q;

  // ============================================================
  // Per-channel datapath
  for (genvar c = 0; c < NUM_CH; c++) begin : gChan
    logic [CNT_W-1:0] wrGray;
    logic [CNT_W-1:0] graySync1_q;
    logic [CNT_W-1:0] graySync2_q;
    logic [CNT_W-1:0] rdPtr_q;
    logic             storeBit;
    logic [NCO_W-1:0] phase_q;
    logic [NCO_W-1:0] baseInc;
    logic [NCO_W-1:0] inc;
    logic [NCO_W:0]   phaseSum;
    logic             bitTick;
    logic             haveBit;
    logic             smoothBit;
    logic [PRBS_W-1:0] prbs_q;
    logic             rxHold_q;
    logic             txBit;
    logic             wrThisCtrl;
    logic             localLoop_q;

    gapped_bit_capture uCapture (
      .clkLink  (tx_gapped_clock_in[c]),
      .rst      (rst),
      .dataIn   (tx_pos_data_in[c]),
      .rdAddr   (rdPtr_q[DEPTH_W-1:0]),
      .rdBit    (storeBit),
      .wrGray_q (wrGray)
    );

    assign wrCount[c] = grayToBin(graySync2_q);
    assign fill[c]    = wrCount[c] - rdPtr_q;
    assign haveBit    = fill[c] != '0;

    // Rate select and elastic-store trim
    assign baseInc = ctrl_q[c].rateE3Select ? NCO_INC_E3 :
                     ctrl_q[c].rateSonetVsT3Select ? NCO_INC_STS1 :
                     NCO_INC_DS3;
    assign inc = (fill[c] > FILL_HIGH) ? baseInc + NCO_TRIM :
                 (fill[c] < FILL_LOW) ? baseInc - NCO_TRIM : baseInc;
    assign phaseSum  = {1'b0, phase_q} + {1'b0, inc};
    assign bitTick   = phaseSum[NCO_W];
    assign smoothBit = haveBit && storeBit;

    assign txBit = ctrl_q[c].testPatternEn ? prbs_q[PRBS_W-1] :
                   ctrl_q[c].remoteLoopbackEn ? rxHold_q : smoothBit;

    assign wrThisCtrl = doWrite && wrCtrlHit[c] && wStrb_q[0];

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        graySync1_q <= '0;
        graySync2_q <= '0;
      end else begin
        graySync1_q <= wrGray;
        graySync2_q <= graySync1_q;
      end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        ctrl_q[c] <= CTRL_RESET;
      end else if (wrThisCtrl) begin
        ctrl_q[c] <= wData_q[7:0] & CTRL_RW_MASK;
      end
    end

    // Smoothed read-out paced by the rate oscillator
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        phase_q <= '0;
        rdPtr_q <= '0;
      end else begin
        phase_q <= phaseSum[NCO_W-1:0];
        if (bitTick && haveBit) begin
          rdPtr_q <= rdPtr_q + 8'h01;
        end
      end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        prbs_q      <= PRBS_SEED;
        rxHold_q    <= 1'b0;
        localLoop_q <= 1'b0;
      end else begin
        if (bitTick) begin
          prbs_q      <= {prbs_q[PRBS_W-2:0], prbs_q[PRBS_W-1] ^ prbs_q[PRBS_W-2]};
          localLoop_q <= ctrl_q[c].localLoopbackEn && txBit;
        end
        if (rxLoopValid[c]) begin
          rxHold_q <= rxLoopBit[c];
        end
      end
    end

    assign localLoopData[c] = localLoop_q;

    line_pulse_encoder uEncoder (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .bitStb     (bitTick),
      .bitIn      (txBit),
      .singleRail (ctrl_q[c].singleRailSelect),
      .linePos_q  (linePos[c]),
      .lineNeg_q  (lineNeg[c]),
      .lineClk_q  (lineBitClk[c])
    );
  end

endmodule // gapped_ds3_tx_input

// *** sim/gapped_ds3_tx_input_checker.sv ***
// Port checker for the gapped DS3 transmit input block
// Assumes it is bound onto the top module, all in the clk_sys domain
module gapped_ds3_tx_input_checker
  import gapped_tx_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input gapped_tx_pkg::axiReq_t axiReq,
  input gapped_tx_pkg::axiRsp_t axiRsp,
  input wire logic [NUM_CH-1:0] linePos,
  input wire logic [NUM_CH-1:0] lineNeg
);
  timeunit 1ns;
  timeprecision 100ps;
  import gapped_tx_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ============================================================
  // Register port handshakes
  sequence s_wTake;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  endsequence
  sequence s_bDone;
    axiRsp.bvalid && axiReq.bready;
  endsequence
  sequence s_rDone;
    axiRsp.rvalid && axiReq.rready;
  endsequence

  a_aw_drop_taken: assert property (
    axiReq.awvalid && axiRsp.awready |=> !axiRsp.awready)
    else $error("awready stayed high after a take");
  a_b_after_both: assert property (s_wTake |-> ##2 axiRsp.bvalid)
    else $error("write response late");
  a_b_holds: assert property (
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped early");
  a_w_ready_back: assert property (
    s_bDone |=> axiRsp.awready && axiRsp.wready)
    else $error("write channel not reopened");
  a_r_answer: assert property (
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read data late");
  a_r_holds: assert property (
    axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped early");
  a_r_ready_back: assert property (s_rDone |=> axiRsp.arready)
    else $error("read channel not reopened");

  // ============================================================
  // Line and reset
  a_rails_apart: assert property ((linePos & lineNeg) == '0)
    else $error("both line rails high");
  a_reset_quiet: assert property (disable iff (1'b0) rst |-> axiRsp == '0)
    else $error("register port active in reset");
endmodule // gapped_ds3_tx_input_checker

// *** sim/gapped_mapper_model.sv ***
// Mapper model: gapped payload clock and data for one channel
// Assumes a free link clock; the output clock stands still while gateEn is low
module gapped_mapper_model (
  input  wire logic clkLink,
  input  wire logic gateEn,
  input  wire logic dataBit,
  output logic      gapClk,
  output logic      dataOut
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] slot_q;
  logic       gate_q;
  initial begin
    slot_q  = 3'h0;
    gate_q  = 1'b0;
    dataOut = 1'b0;
  end
  // Seven payload slots, then one overhead slot with no edge
  always @(negedge clkLink) begin
    slot_q  <= slot_q + 3'h1;
    gate_q  <= gateEn && (slot_q != 3'h6);
    dataOut <= (gateEn && (slot_q != 3'h6)) ? dataBit : ~dataOut;
  end
  assign gapClk = clkLink & gate_q;
endmodule // gapped_mapper_model

// *** sim/gapped_ds3_tx_input_tb_top.sv ***
// Self-checking bench for the gapped DS3 transmit input block
// Assumes the checker is bound at the foot of this file
module gapped_ds3_tx_input_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import gapped_tx_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [1:0]  wr;
    logic [31:0] rd;
    logic [1:0]  rr;
  } regCase_t;
  typedef struct packed {
    logic [7:0] ctrl;
    int rLo; int rHi; int pLo; int pHi; int nLo; int nHi; int lLo; int lHi;
  } rateCase_t;
  localparam regCase_t REG_CASES [6] = '{
    '{12'h018, 32'hFF, RESP_OKAY, 32'h3F, RESP_OKAY},
    '{12'h358, 32'h01, RESP_OKAY, 32'h01, RESP_OKAY},
    '{12'h218, 32'h2A, RESP_OKAY, 32'h2A, RESP_OKAY},
    '{12'h158, 32'h15, RESP_OKAY, 32'h15, RESP_OKAY},
    '{12'h01C, 32'h01, RESP_SLVERR, 32'h00, RESP_SLVERR},
    '{12'h1D8, 32'h01, RESP_SLVERR, 32'h00, RESP_SLVERR}};
  localparam rateCase_t RATE_CASES [9] = '{
    '{8'h01, 410, 480, 1, 1000, 1, 1000, 0, 0},
    '{8'h03, 490, 550, 1, 1000, 1, 1000, 0, 0},
    '{8'h05, 310, 370, 1, 1000, 1, 1000, 0, 0},
    '{8'h07, 310, 370, 1, 1000, 1, 1000, 0, 0},
    '{8'h00, 410, 480, 900, 1000, 0, 0, 0, 0},
    '{8'h09, 410, 480, 1, 1000, 1, 1000, 1, 1000},
    '{8'h10, 410, 480, 0, 0, 0, 0, 0, 0},
    '{8'h20, 410, 480, 200, 800, 0, 0, 0, 0},
    '{8'h30, 410, 480, 200, 800, 0, 0, 0, 0}};
  localparam logic [11:0] STAT_ADDR = {2'b00, CH_PAGE[0], STAT_IDX_LOW, 2'b00};

  logic              clk_sys, rst, clkLink, gateEn, dataBit, mapClk, mapData;
  axiReq_t           axiReq;
  axiRsp_t           axiRsp;
  logic [NUM_CH-1:0] rxLoopBit, rxLoopValid, linePos, lineNeg, lineBitClk, localLoopData;
  logic [31:0]       rdat, c0, c1;
  logic [1:0]        resp;
  int                fails, samples_checked, edges, tog, pos, neg, lp;

  initial begin
    clk_sys = 1'b0;
    clkLink = 1'b0;
    rst = 1'b1;
    axiReq = '0;
    gateEn = 1'b0;
    dataBit = 1'b0;
    rxLoopBit = '0;
    rxLoopValid = '1;
    fails = 0;
    samples_checked = 0;
    edges = 0;
  end
  always #5 clk_sys = ~clk_sys;
  initial begin
    #3.3;
    forever #6 clkLink = ~clkLink;
  end
  always @(posedge mapClk) edges++;

  gapped_mapper_model u_gapped_mapper_model (.clkLink(clkLink), .gateEn(gateEn),
    .dataBit(dataBit), .gapClk(mapClk), .dataOut(mapData));
  gapped_ds3_tx_input u_gapped_ds3_tx_input (.clk_sys(clk_sys), .rst(rst), .axiReq(axiReq),
    .axiRsp(axiRsp), .tx_gapped_clock_in({11'h000, mapClk}),
    .tx_pos_data_in({11'h000, mapData}), .rxLoopBit(rxLoopBit), .rxLoopValid(rxLoopValid),
    .linePos(linePos), .lineNeg(lineNeg), .lineBitClk(lineBitClk),
    .localLoopData(localLoopData));

  // ============================================================
  // Tasks
  function automatic logic [11:0] ctrl_addr(input int ch);
    return {2'b00, CH_PAGE[ch], CTRL_IDX_LOW, 2'b00};
  endfunction
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      fails++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    axiReq <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: s, bready: 1'b1,
                default: '0};
    do begin
      @(posedge clk_sys);
      n++;
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1 && n < 40);
    resp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
    check_range(n, 1, 39);
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    axiReq <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(posedge clk_sys);
      n++;
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1 && n < 40);
    d = axiRsp.rdata;
    resp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
    check_range(n, 1, 39);
  endtask
  task automatic measure_line;
    logic last;
    tog = 0;
    pos = 0;
    neg = 0;
    lp = 0;
    repeat (20) @(posedge clk_sys);
    last = lineBitClk[0];
    repeat (1000) begin
      @(negedge clk_sys);
      tog += int'(lineBitClk[0] !== last);
      last = lineBitClk[0];
      pos += int'(linePos[0] === 1'b1);
      neg += int'(lineNeg[0] === 1'b1);
      lp += int'(localLoopData[0] === 1'b1);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ============================================================
  // Tests
  initial begin
    #200us;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    foreach (REG_CASES[i]) begin
      axi_write(REG_CASES[i].a, REG_CASES[i].d, 4'hF);
      check_val(32'(resp), 32'(REG_CASES[i].wr));
      axi_read(REG_CASES[i].a, rdat);
      check_val(rdat, REG_CASES[i].rd);
      check_val(32'(resp), 32'(REG_CASES[i].rr));
    end
    $display("register table done");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < NUM_CH; i++) begin
      axi_read(ctrl_addr(i), rdat);
      check_val(rdat, {24'h0, CTRL_RESET});
    end
    axi_write(ctrl_addr(0), 32'h3F, 4'h0);
    axi_read(ctrl_addr(0), rdat);
    check_val(rdat, 32'h00);
    $display("reset and strobe done");
    axi_write(ctrl_addr(0), 32'h01, 4'hF);
    axi_read(STAT_ADDR, c0);
    edges = 0;
    gateEn <= 1'b1;
    dataBit <= 1'b1;
    repeat (40) @(posedge clk_sys);
    gateEn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    axi_read(STAT_ADDR, c1);
    check_val({24'h0, c1[7:0]}, {24'h0, c0[7:0] + 8'(edges)});
    repeat (50) @(posedge clk_sys);
    axi_read(STAT_ADDR, c0);
    check_val({24'h0, c0[7:0]}, {24'h0, c1[7:0]});
    $display("gapped capture done");
    gateEn <= 1'b1;
    foreach (RATE_CASES[i]) begin
      axi_write(ctrl_addr(0), {24'h0, RATE_CASES[i].ctrl}, 4'hF);
      measure_line();
      check_range(tog, RATE_CASES[i].rLo, RATE_CASES[i].rHi);
      check_range(pos, RATE_CASES[i].pLo, RATE_CASES[i].pHi);
      check_range(neg, RATE_CASES[i].nLo, RATE_CASES[i].nHi);
      check_range(lp, RATE_CASES[i].lLo, RATE_CASES[i].lHi);
    end
    $display("line modes done");
    finish_test();
  end
endmodule // gapped_ds3_tx_input_tb_top

bind gapped_ds3_tx_input gapped_ds3_tx_input_checker u_gapped_ds3_tx_input_checker (
  .clk_sys(clk_sys), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
  .linePos(linePos), .lineNeg(lineNeg));
